// *** verilog/wwd_pkg.sv ***
// Purpose : shared constants and types of the window watchdog timing block
// Assumes : 100 MHz core clock, internal time base of one tick per 10 us
// Notes   : every time is kept in its own unit and converted to ticks here

package wwd_pkg;

  // ****************************************************************
  // clock and internal time base
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_US       = 10;
  localparam int TICK_CYC      = TICK_US * 1000 / CLK_PERIOD_NS;
  localparam int TDIV_W        = 16;

  // ****************************************************************
  // widths
  // ****************************************************************
  localparam int CNT_W  = 22;   // holds the longest capacitor window
  localparam int CAP_W  = 12;   // capacitance in units of 15.55 pF
  localparam int HOLD_W = 8;
  localparam int FRAC_W = 16;   // fixed point of the capacitor ratio

  // ****************************************************************
  // window lengths
  // ****************************************************************
  localparam int WIN_SHORT_MS = 250;
  localparam int WIN_LONG_MS  = 2500;
  localparam int CAP_BASE_US  = 6250;

  localparam logic [CNT_W-1:0] WIN_SHORT_T =
    CNT_W'(WIN_SHORT_MS * 1000 / TICK_US);
  localparam logic [CNT_W-1:0] WIN_LONG_T  =
    CNT_W'(WIN_LONG_MS * 1000 / TICK_US);
  localparam logic [9:0]       CAP_STEP_T  = 10'(CAP_BASE_US / TICK_US);

  // ****************************************************************
  // lower boundary divisors, scaled by ten
  // ****************************************************************
  localparam int DIV_SHORT_HI = 1249;
  localparam int DIV_LONG_HI  = 1277;
  localparam int DIV_CAP_HI   = 645;
  localparam int DIV_SHORT_LO = 318;
  localparam int DIV_LONG_LO  = 320;
  localparam int DIV_CAP_LO   = 258;
  localparam int DIV_CAP_MAX  = 927;
  localparam int DIV_CAP_MIN  = 516;

  localparam logic [CNT_W-1:0] LB_SHORT_HI =
    CNT_W'(WIN_SHORT_MS * 10000 / (TICK_US * DIV_SHORT_HI));
  localparam logic [CNT_W-1:0] LB_LONG_HI  =
    CNT_W'(WIN_LONG_MS * 10000 / (TICK_US * DIV_LONG_HI));
  localparam logic [CNT_W-1:0] LB_SHORT_LO =
    CNT_W'(WIN_SHORT_MS * 10000 / (TICK_US * DIV_SHORT_LO));
  localparam logic [CNT_W-1:0] LB_LONG_LO  =
    CNT_W'(WIN_LONG_MS * 10000 / (TICK_US * DIV_LONG_LO));

  // reciprocal of the capacitor divisors in 16 fractional bits
  localparam logic [FRAC_W-1:0] CAP_K_HI =
    FRAC_W'((10 << FRAC_W) / DIV_CAP_HI);
  localparam logic [FRAC_W-1:0] CAP_K_LO =
    FRAC_W'((10 << FRAC_W) / DIV_CAP_LO);

  // ****************************************************************
  // supervisor reset pulse after a fault, in ticks
  // ****************************************************************
  localparam logic [HOLD_W-1:0] RST_TICKS = 8'h04;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {ST_HOLD, ST_FIRST, ST_RUN} wwd_state_e;

  typedef struct packed {
    logic             cap_mode;
    logic             timeout_sel;
    logic             ratio_sel;
    logic [CAP_W-1:0] cap_units;
  } wwd_strap_s;

  typedef struct packed {
    logic [CNT_W-1:0] win;
    logic [CNT_W-1:0] lb;
  } wwd_cfg_s;

  typedef struct packed {
    wwd_state_e        state;
    logic [CNT_W-1:0]  cnt;
    logic [HOLD_W-1:0] hold;
    logic              reset_n;
    logic              early;
    logic              late;
  } wwd_core_s;

  typedef struct packed {
    logic [TDIV_W-1:0] div;
    logic              tick;
    logic              trig_s;
    logic              rise;
  } wwd_tick_s;

endpackage

// *** verilog/wwd_tick_gen.sv ***
// Purpose : free running internal time base and trigger edge sampler
// Assumes : trigger input is synchronous to clock_i
// Notes   : the trigger is looked at only once per tick

`timescale 1ns/1ps

module wwd_tick_gen #(
  parameter int TICK_CYC = wwd_pkg::TICK_CYC
) (
  // clock and reset
  input  wire logic clock_i,
  input  wire logic rst_n_i,
  // trigger from the host
  input  wire logic trig_i,
  // time base towards the core
  output logic      tick_o,
  output logic      rise_o
);

  // ****************************************************************
  // state
  // ****************************************************************
  wwd_pkg::wwd_tick_s q_reg;
  wwd_pkg::wwd_tick_s q_next;

  // divider wraps and takes one trigger sample per tick
  always_comb begin
    q_next      = q_reg;
    q_next.tick = 1'b0;
    q_next.rise = 1'b0;
    if (q_reg.div == wwd_pkg::TDIV_W'(TICK_CYC - 1)) begin
      q_next.div    = '0;
      q_next.tick   = 1'b1;
      q_next.trig_s = trig_i;
      // edge counts only from one tick sample to the next
      q_next.rise   = trig_i & ~q_reg.trig_s;
    end else begin
      q_next.div = q_reg.div + 1'b1;
    end
  end

  // state register
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q_reg <= '0;
    end else begin
      q_reg <= q_next;
    end
  end

  assign tick_o = q_reg.tick;
  assign rise_o = q_reg.rise;

  // ****************************************************************
  // checks
  // ****************************************************************
  AST_RISE_ON_TICK: assert property (@(posedge clock_i)
    disable iff (!rst_n_i) rise_o |-> tick_o)
    else $error("edge seen outside a tick");

  AST_RISE_CAUSE: assert property (@(posedge clock_i)
    disable iff (!rst_n_i)
    rise_o |-> $past(trig_i) && $past(q_reg.div) ==
      wwd_pkg::TDIV_W'(TICK_CYC - 1))
    else $error("edge without a sampled high trigger");

endmodule // wwd_tick_gen

// *** verilog/wwd_core.sv ***
// Purpose : window watchdog timing of a supervisory device
// Assumes : straps and trigger are synchronous to clock_i and static
// Notes   : power supervision and power-on delay live elsewhere
//
// Operation
// - trigger sampled by the internal time base; edge counted next tick
// - ratio strap high: boundary is window over 124.9, 127.7, or 64.5
// - ratio strap low: boundary is window over 31.8, 32, or 25.8
// - timeout strap low gives 0.25 s, high 2.5 s, or capacitor sets it
// - capacitor mode, ratio high: divisor stays between 51.6 and 92.7
// - capacitor window is 6.25 ms times one plus units of 15.55 pF
// - missing edge inside the window asserts the reset output
// - no lower boundary check until the first edge after reset release
// - every recognised edge outside the reset pulse, except an early one, clears timers and starts a new boundary

`timescale 1ns/1ps

module wwd_core #(
  parameter int TICK_CYC = wwd_pkg::TICK_CYC
) (
  // clock and reset
  input  wire logic                     clock_i,
  input  wire logic                     rst_n_i,
  // host trigger
  input  wire logic                     watchdog_trigger_in,
  // configuration straps
  input  wire logic                     timeout_select_pin,
  input  wire logic                     ratio_select_pin,
  input  wire logic                     cap_mode_i,
  input  wire logic [wwd_pkg::CAP_W-1:0] cap_units_i,
  // supervisor outputs
  output logic                          wd_reset_n_o,
  output logic                          early_fault_o,
  output logic                          late_fault_o
);

  // ****************************************************************
  // configuration decode
  // ****************************************************************

  // window and lower boundary in ticks for a strap setting
  function automatic wwd_pkg::wwd_cfg_s cfg_of(wwd_pkg::wwd_strap_s s);
    wwd_pkg::wwd_cfg_s                   c;
    logic [wwd_pkg::CAP_W:0]             units;
    logic [wwd_pkg::CNT_W+9:0]           raw;
    logic [wwd_pkg::CNT_W+wwd_pkg::FRAC_W-1:0] prod;
    logic [wwd_pkg::FRAC_W-1:0]          k;
    c     = '0;
    units = {1'b0, s.cap_units} + 1'b1;
    raw   = '0;
    prod  = '0;
    k     = '0;
    if (s.cap_mode) begin
      // one base step per capacitance unit plus one
      raw   = (wwd_pkg::CNT_W+10)'(units) *
              (wwd_pkg::CNT_W+10)'(wwd_pkg::CAP_STEP_T);
      c.win = raw[wwd_pkg::CNT_W-1:0];
      // multiply by a reciprocal: no divider in the path
      k     = s.ratio_sel ? wwd_pkg::CAP_K_HI : wwd_pkg::CAP_K_LO;
      prod  = (wwd_pkg::CNT_W+wwd_pkg::FRAC_W)'(c.win) *
              (wwd_pkg::CNT_W+wwd_pkg::FRAC_W)'(k);
      c.lb  = prod[wwd_pkg::FRAC_W +: wwd_pkg::CNT_W];
    end else if (s.timeout_sel) begin
      c.win = wwd_pkg::WIN_LONG_T;
      c.lb  = s.ratio_sel ? wwd_pkg::LB_LONG_HI
                          : wwd_pkg::LB_LONG_LO;
    end else begin
      c.win = wwd_pkg::WIN_SHORT_T;
      c.lb  = s.ratio_sel ? wwd_pkg::LB_SHORT_HI
                          : wwd_pkg::LB_SHORT_LO;
    end
    return c;
  endfunction

  wwd_pkg::wwd_strap_s strap;
  wwd_pkg::wwd_cfg_s   cfg;

  // straps read live; a change applies at once, also to the window in progress
  // one driver for the whole strap word keeps the member order in one place
  assign strap = {cap_mode_i, timeout_select_pin, ratio_select_pin,
                  cap_units_i};
  assign cfg   = cfg_of(strap);

  // ****************************************************************
  // internal time base
  // ****************************************************************
  logic tick;
  logic rise;

  wwd_tick_gen #(
    .TICK_CYC (TICK_CYC)
  ) u_tick (
    .clock_i  (clock_i),
    .rst_n_i  (rst_n_i),
    .trig_i   (watchdog_trigger_in),
    .tick_o   (tick),
    .rise_o   (rise)
  );

  // ****************************************************************
  // window state machine
  // ****************************************************************
  wwd_pkg::wwd_core_s q_reg;
  wwd_pkg::wwd_core_s q_next;
  logic               in_window;
  logic               too_early;
  logic               too_late;

  // boundary check only once an edge has armed it
  assign in_window = (q_reg.state == wwd_pkg::ST_FIRST) ||
                     (q_reg.state == wwd_pkg::ST_RUN);
  assign too_early = rise && (q_reg.state == wwd_pkg::ST_RUN) &&
                     (q_reg.cnt < cfg.lb);
  assign too_late  = !rise &&
                     ({1'b0, q_reg.cnt} + 1'b1 >= {1'b0, cfg.win});

  // next state; all timers advance on ticks only
  always_comb begin
    q_next       = q_reg;
    q_next.early = 1'b0;
    q_next.late  = 1'b0;
    case (q_reg.state)
      wwd_pkg::ST_HOLD: begin
        q_next.reset_n = 1'b0;
        if (tick) begin
          if (q_reg.hold == wwd_pkg::RST_TICKS - 1'b1) begin
            // release opens a first window without lower check
            q_next.state   = wwd_pkg::ST_FIRST;
            q_next.hold    = '0;
            q_next.cnt     = '0;
            q_next.reset_n = 1'b1;
          end else begin
            q_next.hold = q_reg.hold + 1'b1;
          end
        end
      end
      wwd_pkg::ST_FIRST,
      wwd_pkg::ST_RUN: begin
        if (tick) begin
          if (too_early || too_late) begin
            // a violation pulls reset at once
            q_next.state   = wwd_pkg::ST_HOLD;
            q_next.reset_n = 1'b0;
            q_next.hold    = '0;
            q_next.cnt     = '0;
            q_next.early   = too_early;
            q_next.late    = too_late;
          end else if (rise) begin
            // restart timers, boundary now enforced
            q_next.cnt   = '0;
            q_next.state = wwd_pkg::ST_RUN;
          end else begin
            q_next.cnt = q_reg.cnt + 1'b1;
          end
        end
      end
      default: begin
        q_next         = '0;
        q_next.state   = wwd_pkg::ST_FIRST;
        q_next.reset_n = 1'b1;
      end
    endcase
  end

  // state register; power-on opens a first window
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q_reg         <= '0;
      q_reg.state   <= wwd_pkg::ST_FIRST;
      q_reg.reset_n <= 1'b1;
    end else begin
      q_reg <= q_next;
    end
  end

  // outputs straight from the state register
  assign wd_reset_n_o  = q_reg.reset_n;
  assign early_fault_o = q_reg.early;
  assign late_fault_o  = q_reg.late;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence s_good_edge;
    tick && rise && in_window && !too_early;
  endsequence

  sequence s_missed;
    tick && in_window && too_late;
  endsequence

  sequence s_fault_hold;
    !wd_reset_n_o && q_reg.state == wwd_pkg::ST_HOLD;
  endsequence

  AST_EDGE_CLEARS: assert property (
    s_good_edge |=> q_reg.cnt == '0 && q_reg.state == wwd_pkg::ST_RUN)
    else $error("edge did not restart the window");

  AST_LATE_RESET: assert property (
    s_missed |=> late_fault_o ##0 s_fault_hold ##1 !late_fault_o)
    else $error("missed window did not assert reset");

  AST_EARLY_RESET: assert property (
    tick && rise && q_reg.state == wwd_pkg::ST_RUN &&
    q_reg.cnt < cfg.lb |=> early_fault_o ##0 s_fault_hold)
    else $error("early edge not punished");

  AST_FIRST_FREE: assert property (
    tick && rise && q_reg.state == wwd_pkg::ST_FIRST |=> !early_fault_o)
    else $error("lower boundary enforced in first window");

  AST_RELEASE_FIRST: assert property (
    $rose(wd_reset_n_o) |-> q_reg.state == wwd_pkg::ST_FIRST &&
    q_reg.cnt == '0)
    else $error("release did not open a first window");

  AST_WIN_FIXED: assert property (
    !cap_mode_i |-> cfg.win == (timeout_select_pin ?
      wwd_pkg::WIN_LONG_T : wwd_pkg::WIN_SHORT_T))
    else $error("fixed window length wrong");

  AST_LB_RATIO_HI: assert property (
    !cap_mode_i && ratio_select_pin |-> cfg.lb == (timeout_select_pin ?
      wwd_pkg::LB_LONG_HI : wwd_pkg::LB_SHORT_HI))
    else $error("high ratio boundary wrong");

  AST_LB_RATIO_LO: assert property (
    !cap_mode_i && !ratio_select_pin |-> cfg.lb == (timeout_select_pin ?
      wwd_pkg::LB_LONG_LO : wwd_pkg::LB_SHORT_LO))
    else $error("low ratio boundary wrong");

  AST_CAP_WINDOW: assert property (
    cap_mode_i |-> 32'(cfg.win) ==
      (32'(cap_units_i) + 1) * 32'(wwd_pkg::CAP_STEP_T))
    else $error("capacitor window length wrong");

  AST_CAP_RATIO: assert property (
    cap_mode_i && ratio_select_pin |->
      64'(cfg.lb) * wwd_pkg::DIV_CAP_MIN <= 64'(cfg.win) * 10 &&
      64'(cfg.lb) * wwd_pkg::DIV_CAP_MAX >= 64'(cfg.win) * 10)
    else $error("capacitor ratio outside its band");

  AST_CFG_STATIC: assert property (
    $stable(strap) |-> $stable(cfg))
    else $error("window setting moved with steady straps");

endmodule // wwd_core

// *** verif/wwd_host_model.sv ***
// Purpose : host side that services the watchdog trigger
// Assumes : trigger edges are placed on whole tick multiples
// Notes   : a go request sets the spacing of the next rising edge

`timescale 1ns/1ps

module wwd_host_model #(
  parameter int TICK_CYC = 2
) (
  // clock and reset
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  // request from the bench
  input  wire logic        go_i,
  input  wire logic [15:0] gap_i,
  // trigger towards the device
  output logic             trig_o,
  output logic             busy_o
);
  // ****************************************************************
  // edge scheduler
  // ****************************************************************
  logic [31:0] since_reg;
  logic [15:0] gap_reg;

  // spacing counts from the previous rise, so the bench may ask late
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      since_reg <= 32'h0;
      gap_reg   <= 16'h0;
      trig_o    <= 1'b0;
      busy_o    <= 1'b0;
    end else begin
      since_reg <= since_reg + 32'h1;
      if (go_i && !busy_o) begin
        busy_o  <= 1'b1;
        gap_reg <= gap_i;
      end
      // rise exactly gap ticks after the last one
      if (busy_o && (since_reg + 32'h1 >= 32'(gap_reg) * TICK_CYC)) begin
        trig_o    <= 1'b1;
        since_reg <= 32'h0;
        busy_o    <= 1'b0;
      end
      // held two ticks so one tick sample surely sees it high
      if (trig_o && since_reg == 32'(2 * TICK_CYC - 1)) begin
        trig_o <= 1'b0;
      end
    end
  end

endmodule // wwd_host_model

// *** verif/window_watchdog_timing_test.sv ***
// Purpose : self-checking bench of the window watchdog core
// Assumes : a short tick so that every window fits the run
// Notes   : edge spacing is in ticks; margins of two ticks cover phase

`timescale 1ns/1ps

module window_watchdog_timing_test;
  // ****************************************************************
  // bench settings and signals
  // ****************************************************************
  localparam int TC = 2;
  typedef struct {
    logic        to;
    logic        ra;
    logic        cm;
    logic [11:0] units;
    int          win;
    int          div;
  } wwd_row_s;

  logic        clock_i;
  logic        rst_n_i;
  logic        trig;
  logic        go;
  logic [15:0] gap;
  logic        busy;
  logic        to_sel;
  logic        ra_sel;
  logic        cap_mode;
  logic [11:0] cap_units;
  logic        wd_reset_n;
  logic        early;
  logic        late;
  int          num_errors;
  int          num_checks;
  int          early_cnt;
  int          late_cnt;
  int          low_cnt;
  int          lb;
  wwd_row_s    rows [6];

  // ****************************************************************
  // design and host
  // ****************************************************************
  wwd_core #(.TICK_CYC(TC)) dut (
    .clock_i            (clock_i),
    .rst_n_i            (rst_n_i),
    .watchdog_trigger_in(trig),
    .timeout_select_pin (to_sel),
    .ratio_select_pin   (ra_sel),
    .cap_mode_i         (cap_mode),
    .cap_units_i        (cap_units),
    .wd_reset_n_o       (wd_reset_n),
    .early_fault_o      (early),
    .late_fault_o       (late)
  );

  wwd_host_model #(.TICK_CYC(TC)) host (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .go_i   (go),
    .gap_i  (gap),
    .trig_o (trig),
    .busy_o (busy)
  );

  // clock of 100 MHz
  always #5 clock_i = ~clock_i;

  // output monitor, cleared by every reset
  always @(posedge clock_i) begin
    if (!rst_n_i) begin
      early_cnt = 0;
      late_cnt  = 0;
      low_cnt   = 0;
    end else begin
      if (early === 1'b1) early_cnt++;
      if (late === 1'b1) late_cnt++;
      if (wd_reset_n === 1'b0) low_cnt++;
    end
  end

  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %s seen %0h expected %0h",
               $time, what, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    if (num_errors == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic do_reset(input int cyc);
    @(posedge clock_i);
    #1 rst_n_i = 1'b0;
    repeat (cyc) @(posedge clock_i);
    #1 rst_n_i = 1'b1;
  endtask

  // one rising edge gap ticks after the last, then the answer time
  task automatic host_edge(input int g);
    int n;
    @(posedge clock_i);
    #1 go = 1'b1;
    gap = 16'(g);
    @(posedge clock_i);
    #1 go = 1'b0;
    n = 0;
    while (busy === 1'b1 && n < (g + 8) * TC) begin
      @(posedge clock_i);
      #1 n++;
    end
    if (n >= (g + 8) * TC) begin
      check(1'b0, 1'b1, "host edge timed out");
      tally_and_finish();
    end
    repeat (TC + 3) @(posedge clock_i);
    #1;
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    clock_i = 1'b0;
    rst_n_i = 1'b0;
    go = 1'b0;
    gap = 16'h0;
    to_sel = 1'b0;
    ra_sel = 1'b1;
    cap_mode = 1'b0;
    cap_units = 12'h000;
    num_errors = 0;
    num_checks = 0;
    // window in 10 us ticks beside the divisor scaled by ten
    rows[0] = '{1'b0, 1'b1, 1'b0, 12'h000, 25000, wwd_pkg::DIV_SHORT_HI};
    rows[1] = '{1'b0, 1'b0, 1'b0, 12'h000, 25000, wwd_pkg::DIV_SHORT_LO};
    rows[2] = '{1'b1, 1'b1, 1'b0, 12'h000, 250000, wwd_pkg::DIV_LONG_HI};
    rows[3] = '{1'b1, 1'b0, 1'b0, 12'h000, 250000, wwd_pkg::DIV_LONG_LO};
    rows[4] = '{1'b0, 1'b1, 1'b1, 12'h003, 2500, wwd_pkg::DIV_CAP_HI};
    rows[5] = '{1'b1, 1'b0, 1'b1, 12'h003, 2500, wwd_pkg::DIV_CAP_LO};
    repeat (16) @(posedge clock_i);
    #1 rst_n_i = 1'b1;
    @(posedge clock_i);
    #1;
    check(wd_reset_n, 1'b1, "reset output after power-on");
    check(early, 1'b0, "early fault after power-on");
    check(late, 1'b0, "late fault after power-on");

    // each strap setting: edge just past the boundary, then just before
    foreach (rows[i]) begin
      to_sel = rows[i].to;
      ra_sel = rows[i].ra;
      cap_mode = rows[i].cm;
      cap_units = rows[i].units;
      lb = rows[i].win * 10 / rows[i].div;
      if (rows[i].cm && rows[i].ra) begin
        check(lb * wwd_pkg::DIV_CAP_MIN <= rows[i].win * 10 &&
              rows[i].win * 10 <= lb * wwd_pkg::DIV_CAP_MAX,
              1'b1, "capacitor ratio band");
      end
      do_reset(4);
      check(dut.cfg.win, rows[i].win, "window in ticks");
      check(dut.cfg.lb, lb, "boundary in ticks");
      host_edge(4);
      check(early_cnt, 0, "early edge in first window");
      host_edge(lb + 2);
      check(early_cnt, 0, "edge past boundary");
      check(wd_reset_n, 1'b1, "reset after good edge");
      host_edge(lb - 2);
      check(early_cnt, 1, "edge before boundary");
      check(wd_reset_n, 1'b0, "reset after early edge");
    end

    // missing edge: capacitor mode, smallest window of 625 ticks
    cap_mode = 1'b1;
    cap_units = 12'h000;
    ra_sel = 1'b1;
    do_reset(4);
    host_edge(4);
    repeat ((625 - 8) * TC) @(posedge clock_i);
    #1;
    check(late_cnt, 0, "late fault before window end");
    repeat (8 * TC) @(posedge clock_i);
    #1;
    check(late_cnt, 1, "late fault at window end");
    check(early_cnt, 0, "no early fault on timeout");
    repeat (8 * TC) @(posedge clock_i);
    #1;
    check(low_cnt >= 3 * TC && low_cnt <= 5 * TC + 2, 1'b1,
          "reset pulse length");
    check(wd_reset_n, 1'b1, "reset released after pulse");
    tally_and_finish();
  end

endmodule // window_watchdog_timing_test
